// >>> bench/ais_core_asserts.sv
// Port checks for the ALU subset core
`timescale 1ns/1ps
module ais_core_chk (
	input wire i_clk,
	input wire i_reset_n,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] o_avs_readdata,
	input wire o_avs_waitrequest,
	input wire o_sleep,
	input wire o_busy,
	input wire o_skip_pending
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);
	// Bus answer: one low cycle, two edges after an idle request
	AST_WAIT_ONE: assert property (!o_avs_waitrequest
		|=> o_avs_waitrequest) else $error("long answer");
	AST_ANSWER: assert property (($rose(i_avs_read) || $rose(i_avs_write))
		&& !o_busy |-> ##2 !o_avs_waitrequest) else $error("late answer");
	AST_NO_GHOST: assert property (!o_avs_waitrequest
		|-> i_avs_read || i_avs_write) else $error("answer w/o request");
	// Read data must stand until the next read completes
	AST_RDATA: assert property ($changed(o_avs_readdata)
		|-> !o_avs_waitrequest && i_avs_read) else $error("rdata moved");
	// Four phases: the first of one or two clocks, the others of two each
	AST_BUSY_MIN: assert property ($rose(o_busy)
		|-> o_busy[*6]) else $error("short exec");
	AST_BUSY_MAX: assert property ($rose(o_busy)
		|-> ##[7:12] !o_busy) else $error("long exec");
	// Halt comes out of an executing power-down and then holds
	AST_SLEEP_SRC: assert property ($rose(o_sleep)
		|-> $past(o_busy)) else $error("sleep w/o exec");
	AST_SLEEP_HOLD: assert property ($rose(o_sleep)
		|-> o_sleep[*8]) else $error("sleep dropped");
	AST_SKIP_SRC: assert property ($rose(o_skip_pending)
		|-> $past(o_busy)) else $error("skip w/o exec");
	// A pending skip is only consumed by the next executing word
	AST_SKIP_USE: assert property ($fell(o_skip_pending)
		|-> $past(o_busy)) else $error("skip lost");
	C_SLEEP: cover property ($rose(o_sleep));
	C_SKIP: cover property ($rose(o_skip_pending));
	C_DONE: cover property ($fell(o_busy));
endmodule // ais_core_chk
bind ais_core ais_core_chk ais_core_chk_inst (.i_clk(i_clk),
	.i_reset_n(i_reset_n), .i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .o_sleep(o_sleep),
	.o_busy(o_busy), .o_skip_pending(o_skip_pending));

// >>> bench/alu_instruction_subset_tb.sv
// Self-checking bench for the ALU subset core
`timescale 1ns/1ps
`include "ais_map.vh"
module alu_instruction_subset_tb;
	logic i_clk = 0;
	logic i_reset_n = 0;
	logic [4:0] adr = 0;
	logic rd = 0;
	logic we = 0;
	logic [31:0] wd = 0;
	wire [31:0] q_w;
	wire wait_w;
	wire sleep_w;
	wire busy_w;
	wire skp_w;
	logic [3:0] be = 4'hf;
	int mismatches = 0;
	int n_compared = 0;
	int seed = 32'h4fc3;
	int i;
	logic [31:0] k;
	logic [13:0] ins;
	logic [7:0] acc, fd, res;
	logic [2:0] fl, nf, sel;
	logic dd, sk, skp, pd;

	always #5 i_clk = ~i_clk;

	ais_core ais_core_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(we),
		.i_avs_writedata(wd), .i_avs_byteenable(be),
		.o_avs_readdata(q_w), .o_avs_waitrequest(wait_w),
		.o_sleep(sleep_w), .o_busy(busy_w), .o_skip_pending(skp_w));

	// One access; held until waitrequest is seen low, however long
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge i_clk);
		rd <= !w;
		we <= w;
		adr <= a;
		wd <= d;
		do @(posedge i_clk);
		while (wait_w !== 1'b0);
		q = q_w;
		rd <= 0;
		we <= 0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1, a, d, q);
	endtask

	task automatic chk(input logic [4:0] a, input logic [31:0] e,
		input logic [31:0] m);
		logic [31:0] q;
		bus(0, a, 0, q);
		n_compared++;
		if ((q & m) !== e) begin
			mismatches++;
			$display("BAD %0t at %h got %h", $time, a, q);
		end
	endtask

	// Status pins against the model: busy, skip pending, sleep
	task automatic pins(input logic [2:0] e);
		n_compared++;
		if ({busy_w, skp_w, sleep_w} !== e) begin
			mismatches++;
			$display("BAD %0t pins got %b", $time, {busy_w, skp_w, sleep_w});
		end
	endtask

	task close_out;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Hang guard, far beyond the few thousand cycles the run needs
	initial begin
		#300000;
		mismatches++;
		close_out;
	end

	initial begin
		repeat (20) @(posedge i_clk);
		i_reset_n <= 1;
		chk(`AIS_OFF_STATUS, 32'h18, '1);
		chk(`AIS_OFF_ACC, 32'h0, '1);
		chk(5'h1c, 32'h0, '1);
		// Let the watchdog count up so its clearing is visible
		repeat (600) @(posedge i_clk);
		wr(`AIS_OFF_INSTR, {18'h0, `AIS_OP_SLEEP});
		chk(`AIS_OFF_CTRL, 32'h1, '1);
		pins(3'b001);
		chk(`AIS_OFF_STATUS, 32'h10, '1);
		chk(`AIS_OFF_WDOG, 32'h0, 32'hff);
		wr(`AIS_OFF_CTRL, 32'h1);
		chk(`AIS_OFF_CTRL, 32'h0, '1);
		pins(3'b000);
		// A write with the low lane off must leave the accumulator alone
		be <= 4'he;
		wr(`AIS_OFF_ACC, 32'ha5);
		be <= 4'hf;
		chk(`AIS_OFF_ACC, 32'h0, '1);
		pd = 0;
		skp = 0;
		// Random operands; INCSKIP file data forced all-ones when k[31] is set, to reach the skip path
		for (i = 0; i < 60; i++) begin
			k = $random(seed);
			acc = k[7:0];
			fd = k[23:16];
			fl = k[26:24];
			dd = k[27];
			sel = k[30:28] % 5;
			sk = 0;
			if (sel == 0 && k[31])
				fd = 8'hff;
			if (sel > 2)
				dd = 0;
			wr(`AIS_OFF_ACC, {24'h0, acc});
			wr(`AIS_OFF_FADDR, {25'h0, k[14:8]});
			wr(`AIS_OFF_FDATA, {24'h0, fd});
			wr(`AIS_OFF_STATUS, {29'h0, fl});
			nf = fl;
			res = fd - acc;
			case (sel)
			0: begin
				ins = {`AIS_OP_INCSKIP, dd, k[14:8]};
				res = fd + 8'h01;
				sk = res == 8'h00;
			end
			2: begin
				ins = {`AIS_OP_SWAP, dd, k[14:8]};
				res = {fd[3:0], fd[7:4]};
			end
			3: begin
				ins = {`AIS_OP_ORLIT, fd};
				res = acc | fd;
				nf[2] = res == 8'h00;
			end
			default: begin
				ins = sel == 1 ? {`AIS_OP_FSUB, dd, k[14:8]} :
					{`AIS_OP_LSUB, k[31], fd};
				nf = {res == 0, fd[3:0] >= acc[3:0],
					fd >= acc};
			end
			endcase
			// A pending skip swallows this word whole
			if (skp)
				skp = 0;
			else begin
				skp = sk;
				fl = nf;
				if (dd)
					fd = res;
				else
					acc = res;
			end
			wr(`AIS_OFF_INSTR, {18'h0, ins});
			chk(`AIS_OFF_ACC, {24'h0, acc}, '1);
			chk(`AIS_OFF_FDATA, {24'h0, fd}, '1);
			chk(`AIS_OFF_STATUS, {28'h1, pd, fl}, '1);
			chk(`AIS_OFF_CTRL, {30'h0, skp, 1'b0}, '1);
			pins({1'b0, skp, 1'b0});
		end
		close_out;
	end
endmodule // alu_instruction_subset_tb

// >>> verilog/ais_core.v
// Four-phase execute unit for six ALU instructions with Avalon-MM registers
`timescale 1ns/1ps
`include "ais_map.vh"
module ais_core (
	input wire i_clk,
	input wire i_reset_n,
	input wire [4:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire [3:0] i_avs_byteenable,
	output wire [31:0] o_avs_readdata,
	output wire o_avs_waitrequest,
	output wire o_sleep,
	output wire o_busy,
	output wire o_skip_pending
);

// Bus handshake state
reg wait_r;
reg acc_r;
reg [31:0] rdata_r;
reg [31:0] rdata_nxt;

// Architectural state
reg [7:0] acc_reg_r;
reg carry_r;
reg digit_borrow_flag_r;
reg zero_r;
reg sleep_entered_flag_n_r;
reg watchdog_expiry_flag_n_r;
reg [13:0] ir_r;
reg [6:0] faddr_r;
reg sleep_r;
reg skip_r;

// Execution sequencer
reg run_r;
reg nop_r;
reg [1:0] q_r;
reg [1:0] div_r;
reg q_tick_r;
reg [7:0] res_r;
reg res_c_r;
reg res_dc_r;
reg res_z_r;
reg [7:0] hold_r;
reg hold_c_r;
reg hold_dc_r;
reg hold_z_r;

// Watchdog counter and its prescaler
reg [7:0] watchdog_counter_r;
reg [7:0] wdog_pre_r;

wire [7:0] mem_rd;

// Decode of the held instruction word; words outside the six forms
// match nothing and run as four-phase no-ops
wire is_inc = (ir_r[13:8] == `AIS_OP_INCSKIP);
wire is_fsub = (ir_r[13:8] == `AIS_OP_FSUB);
wire is_swap = (ir_r[13:8] == `AIS_OP_SWAP);
wire is_or = (ir_r[13:8] == `AIS_OP_ORLIT);
wire is_lsub = (ir_r[13:9] == `AIS_OP_LSUB);
wire is_sleep = (ir_r == `AIS_OP_SLEEP);
wire is_file = is_inc | is_fsub | is_swap;
wire dst_file = ir_r[7];
wire [6:0] op_faddr = ir_r[6:0];

// Operand is the literal for literal forms, else the file byte read in Q2
wire [7:0] opnd = (is_or | is_lsub) ? ir_r[7:0] : mem_rd;

// Subtraction as operand plus inverted accumulator plus one
wire [8:0] diff = {1'b0, opnd} + {1'b0, ~acc_reg_r} + 9'h001;
wire [4:0] ndiff = {1'b0, opnd[3:0]} + {1'b0, ~acc_reg_r[3:0]} + 5'h01;

// Phase strobes
wire tick = q_tick_r & run_r;
wire at_dec = tick & (q_r == `AIS_Q_DECODE);
wire at_proc = tick & (q_r == `AIS_Q_PROC);
wire at_wr = tick & (q_r == `AIS_Q_WRITE);
wire commit = at_wr & ~nop_r;

// Bus side decode, valid in the cycle whose closing edge drops waitrequest
wire bus_wr = acc_r & i_avs_write;
wire bus_rd = acc_r & i_avs_read;
wire [31:0] be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
	{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
wire [31:0] wd = i_avs_writedata & be_mask;
wire lane0 = i_avs_byteenable[0];
wire lane01 = i_avs_byteenable[0] | i_avs_byteenable[1];
wire wr_ctrl = bus_wr & (i_avs_address == `AIS_OFF_CTRL) & lane0;
wire wr_instr = bus_wr & (i_avs_address == `AIS_OFF_INSTR) & lane01;
wire wr_acc = bus_wr & (i_avs_address == `AIS_OFF_ACC) & lane0;
wire wr_stat = bus_wr & (i_avs_address == `AIS_OFF_STATUS) & lane0;
wire wr_faddr = bus_wr & (i_avs_address == `AIS_OFF_FADDR) & lane0;
wire wr_fdata = bus_wr & (i_avs_address == `AIS_OFF_FDATA) & lane0;

// File port: the core owns it while running, software otherwise
wire core_fwe = commit & is_file & dst_file;
wire mem_we = core_fwe | wr_fdata;
wire [6:0] mem_waddr = run_r ? op_faddr : faddr_r;
// The write phase stores the value latched in the process phase, so a
// late change on the read port cannot reach the file
wire [7:0] mem_wdata = run_r ? hold_r : wd[7:0];
wire [6:0] mem_raddr = run_r ? op_faddr : faddr_r;

// Watchdog overflow wakes a sleeping core and flags the expiry
// after 65536 clocks, when prescaler and counter both roll over
wire wdog_wrap = (wdog_pre_r == 8'hff) & (watchdog_counter_r == 8'hff);

ais_file_ram u_file (
	.i_clk(i_clk),
	.i_reset_n(i_reset_n),
	.i_we(mem_we),
	.i_waddr(mem_waddr),
	.i_wdata(mem_wdata),
	.i_raddr(mem_raddr),
	.o_rdata(mem_rd)
);

// Phase divider; gating it while asleep stands in for the stopped oscillator
// Limitation: a word written while asleep waits for wake before it runs.
always @(posedge i_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		div_r <= 2'd0;
		q_tick_r <= 1'b0;
	end else if (sleep_r) begin
		div_r <= 2'd0;
		q_tick_r <= 1'b0;
	end else if (div_r == `AIS_Q_DIV - 2'd1) begin
		div_r <= 2'd0;
		q_tick_r <= 1'b1;
	end else begin
		div_r <= div_r + 2'd1;
		q_tick_r <= 1'b0;
	end
end

// Result and flag preparation for the process phase
always @* begin
	res_r = 8'h00;
	res_c_r = carry_r;
	res_dc_r = digit_borrow_flag_r;
	res_z_r = zero_r;
	if (is_inc) begin
		res_r = opnd + 8'h01;
	end else if (is_fsub | is_lsub) begin
		res_r = diff[7:0];
		res_c_r = diff[8];
		res_dc_r = ndiff[4];
		res_z_r = (diff[7:0] == 8'h00);
	end else if (is_or) begin
		res_r = acc_reg_r | ir_r[7:0];
		res_z_r = ((acc_reg_r | ir_r[7:0]) == 8'h00);
	end else if (is_swap) begin
		res_r = {opnd[3:0], opnd[7:4]};
	end
end

// Registers held across the process phase so Q4 writes a stable value
always @(posedge i_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		hold_r <= 8'h00;
		hold_c_r <= 1'b0;
		hold_dc_r <= 1'b0;
		hold_z_r <= 1'b0;
	end else if (at_proc) begin
		hold_r <= res_r;
		hold_c_r <= res_c_r;
		hold_dc_r <= res_dc_r;
		hold_z_r <= res_z_r;
	end
end

// Sequencer: idle until an instruction word arrives, then four phases.
// The bus stalls while busy, so no second word lands mid-instruction;
// a squashed word still takes its four phases, only its commit is masked.
always @(posedge i_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		run_r <= 1'b0;
		q_r <= `AIS_Q_DECODE;
		nop_r <= 1'b0;
		ir_r <= `AIS_INSTR_RST;
	end else if (!run_r) begin
		if (wr_instr) begin
			ir_r <= wd[13:0];
			run_r <= 1'b1;
			q_r <= `AIS_Q_DECODE;
		end
	end else if (tick) begin
		if (at_dec) begin
			nop_r <= skip_r;
		end
		if (at_wr) begin
			run_r <= 1'b0;
		end
		q_r <= q_r + 2'd1;
	end
end

// Architectural registers; the bus only reaches them while the core idles
// so a software write can never race a commit on the same flag
always @(posedge i_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		acc_reg_r <= `AIS_ACC_RST;
		{zero_r, digit_borrow_flag_r, carry_r} <= `AIS_FLAGS_RST;
		faddr_r <= 7'h00;
		skip_r <= 1'b0;
	end else begin
		if (at_dec) begin
			skip_r <= 1'b0;
		end
		if (commit) begin
			if (is_inc) begin
				skip_r <= (hold_r == 8'h00);
			end
			if (is_or | is_lsub) begin
				acc_reg_r <= hold_r;
			end else if (is_file & ~dst_file) begin
				acc_reg_r <= hold_r;
			end
			if (is_fsub | is_lsub) begin
				carry_r <= hold_c_r;
				digit_borrow_flag_r <= hold_dc_r;
			end
			if (is_fsub | is_lsub | is_or) begin
				zero_r <= hold_z_r;
			end
		end
		if (wr_acc) begin
			acc_reg_r <= wd[7:0];
		end
		if (wr_stat) begin
			carry_r <= wd[`AIS_ST_C];
			digit_borrow_flag_r <= wd[`AIS_ST_DC];
			zero_r <= wd[`AIS_ST_Z];
		end
		if (wr_faddr) begin
			faddr_r <= wd[6:0];
		end
	end
end

// Power-down state, reset flags and watchdog. A power-down commit outranks
// a wrap in the same cycle: it restarts the count, so that wrap is stale.
always @(posedge i_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		sleep_r <= 1'b0;
		sleep_entered_flag_n_r <= 1'b1;
		watchdog_expiry_flag_n_r <= 1'b1;
		watchdog_counter_r <= 8'h00;
		wdog_pre_r <= 8'h00;
	end else if (commit & is_sleep) begin
		sleep_r <= 1'b1;
		watchdog_counter_r <= 8'h00;
		wdog_pre_r <= 8'h00;
		sleep_entered_flag_n_r <= 1'b0;
		watchdog_expiry_flag_n_r <= 1'b1;
	end else begin
		// The watchdog keeps its own time, so it runs while asleep
		wdog_pre_r <= wdog_pre_r + 8'h01;
		if (wdog_pre_r == 8'hff) begin
			watchdog_counter_r <= watchdog_counter_r + 8'h01;
		end
		if (wdog_wrap) begin
			watchdog_expiry_flag_n_r <= 1'b0;
			sleep_r <= 1'b0;
		end else if (wr_ctrl & wd[`AIS_CTRL_WAKE]) begin
			sleep_r <= 1'b0;
		end
	end
end

// Read multiplexer; unmapped offsets read as zero
// The power-down and time-out flags read back active low, as stored
always @* begin
	rdata_nxt = 32'h0000_0000;
	case (i_avs_address)
	`AIS_OFF_CTRL: begin
		rdata_nxt[`AIS_CTRL_SLEEP] = sleep_r;
		rdata_nxt[`AIS_CTRL_SKIP] = skip_r;
		rdata_nxt[`AIS_CTRL_BUSY] = run_r;
	end
	`AIS_OFF_INSTR: rdata_nxt[13:0] = ir_r;
	`AIS_OFF_ACC: rdata_nxt[7:0] = acc_reg_r;
	`AIS_OFF_STATUS: begin
		rdata_nxt[`AIS_ST_C] = carry_r;
		rdata_nxt[`AIS_ST_DC] = digit_borrow_flag_r;
		rdata_nxt[`AIS_ST_Z] = zero_r;
		rdata_nxt[`AIS_ST_PD] = sleep_entered_flag_n_r;
		rdata_nxt[`AIS_ST_TO] = watchdog_expiry_flag_n_r;
	end
	`AIS_OFF_FADDR: rdata_nxt[6:0] = faddr_r;
	`AIS_OFF_FDATA: rdata_nxt[7:0] = mem_rd;
	`AIS_OFF_WDOG: rdata_nxt[15:0] = {wdog_pre_r, watchdog_counter_r};
	default: rdata_nxt = 32'h0000_0000;
	endcase
end

// Avalon handshake: accept only while idle so the file port is free;
// one cycle to settle the read data, then waitrequest drops for one cycle.
// Writes land on the edge that drops waitrequest; the master keeps its
// request up one more edge, which the low-waitrequest branch ignores.
always @(posedge i_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		wait_r <= 1'b1;
		acc_r <= 1'b0;
		rdata_r <= 32'h0000_0000;
	end else if (acc_r) begin
		acc_r <= 1'b0;
		wait_r <= 1'b0;
		if (bus_rd) begin
			rdata_r <= rdata_nxt;
		end
	end else if (!wait_r) begin
		wait_r <= 1'b1;
	end else if ((i_avs_read | i_avs_write) & ~run_r) begin
		acc_r <= 1'b1;
	end
end

assign o_avs_readdata = rdata_r;
assign o_avs_waitrequest = wait_r;
assign o_sleep = sleep_r;
assign o_busy = run_r;
assign o_skip_pending = skip_r;

endmodule // ais_core

// >>> verilog/ais_file_ram.v
// Data file memory, 128 bytes, one write port and a registered read port
`timescale 1ns/1ps
module ais_file_ram (
	input wire i_clk,
	input wire i_reset_n,
	input wire i_we,
	input wire [6:0] i_waddr,
	input wire [7:0] i_wdata,
	input wire [6:0] i_raddr,
	output wire [7:0] o_rdata
);

reg [7:0] mem [0:127];
reg [7:0] rdata_r;

// Write port; the array itself has no reset, like real file RAM
always @(posedge i_clk) begin
	if (i_we) begin
		mem[i_waddr] <= i_wdata;
	end
end

// Read data registered every cycle so it is stable for a whole phase
always @(posedge i_clk or negedge i_reset_n) begin
	if (!i_reset_n) begin
		rdata_r <= 8'h00;
	end else begin
		rdata_r <= mem[i_raddr];
	end
end

assign o_rdata = rdata_r;

endmodule // ais_file_ram

// >>> verilog/ais_map.vh
// Register offsets, field positions, opcodes and timing for the ALU subset
`ifndef AIS_MAP_VH
`define AIS_MAP_VH

// Register byte offsets on the Avalon-MM slave
`define AIS_OFF_CTRL 5'h00
`define AIS_OFF_INSTR 5'h04
`define AIS_OFF_ACC 5'h08
`define AIS_OFF_STATUS 5'h0c
`define AIS_OFF_FADDR 5'h10
`define AIS_OFF_FDATA 5'h14
`define AIS_OFF_WDOG 5'h18

// Control register fields
`define AIS_CTRL_WAKE 0
`define AIS_CTRL_SLEEP 0
`define AIS_CTRL_SKIP 1
`define AIS_CTRL_BUSY 2

// Status register fields
`define AIS_ST_C 0
`define AIS_ST_DC 1
`define AIS_ST_Z 2
`define AIS_ST_PD 3
`define AIS_ST_TO 4

// Opcode patterns
`define AIS_OP_INCSKIP 6'h0f
`define AIS_OP_FSUB 6'h02
`define AIS_OP_SWAP 6'h0e
`define AIS_OP_ORLIT 6'h38
`define AIS_OP_LSUB 5'h1e
`define AIS_OP_SLEEP 14'h0063

// Phase timing: clocks per phase and the index of each of the four phases
`define AIS_Q_DIV 2'd2
`define AIS_Q_DECODE 2'd0
`define AIS_Q_READ 2'd1
`define AIS_Q_PROC 2'd2
`define AIS_Q_WRITE 2'd3

// Reset values
`define AIS_ACC_RST 8'h00
`define AIS_FLAGS_RST 3'h0
`define AIS_INSTR_RST 14'h0000

`endif
